/* can_flags_consts.vh */
`ifndef CAN_FLAGS_CONSTS_VH
`define CAN_FLAGS_CONSTS_VH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define ADDR_W 16
`define REG_EVENT_FLAGS 16'h1050
`define REG_CONTROL 16'h1054
`define REG_STATUS 16'h1058
`define EVENT_FLAGS_RESET 32'h00000000

// ----------------------------------------------------------------------
// Flag bit positions
// ----------------------------------------------------------------------
`define BIT_RX_BUFFER_STORED 19
`define BIT_TIMEOUT 18
`define BIT_RAM_ACCESS_FAILURE 17
`define BIT_STAMP_WRAP 16
`define BIT_TX_EVENT_LOST 15
`define BIT_TX_EVENT_FULL 14
`define FLAGS_HI 19
`define FLAGS_LO 14

// ----------------------------------------------------------------------
// Control and status fields
// ----------------------------------------------------------------------
`define BIT_RESTRICTED_SELECT 0
`define STAMP_W 16
`define STAMP_MAX 16'hFFFF

`endif

/* can_interrupt_flags_hi_mid.v */
`include "can_flags_consts.vh"
`timescale 1ns/10ps

module can_interrupt_flags_hi_mid (
    // Clock and reset
    input wire mclk,
    input wire rst_n,
    // Register port
    input wire [`ADDR_W-1:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    // Receive handler
    input wire rx_busy,
    input wire rx_store_done,
    input wire rx_is_dedicated,
    input wire rx_write_error,
    input wire next_arbitration,
    output wire rx_commit,
    output wire rx_abort,
    // Transmit handler
    input wire tx_fetch_late,
    output wire tx_abort,
    // Timeout and timestamp
    input wire timeout_event,
    input wire [`STAMP_W-1:0] stamp_value,
    // Transmit event FIFO
    input wire tx_event_write,
    input wire [5:0] tx_event_size,
    input wire [5:0] tx_event_fill,
    // Mode outputs
    output reg restricted_operation_select,
    output wire [5:0] flags_out
);

// ----------------------------------------------------------------------
// Event sources
// ----------------------------------------------------------------------

wire rx_buffer_stored;
wire wrap_pulse;

// Receive abort decision and the dedicated buffer store event.
rx_store_guard u_guard (
    .mclk(mclk),
    .rst_n(rst_n),
    .rx_busy(rx_busy),
    .rx_store_done(rx_store_done),
    .rx_is_dedicated(rx_is_dedicated),
    .rx_write_error(rx_write_error),
    .next_arbitration(next_arbitration),
    .rx_commit(rx_commit),
    .rx_abort(rx_abort),
    .rx_buffer_stored(rx_buffer_stored)
);

// Timestamp rollover detection.
stamp_wrap_detect u_wrap (
    .mclk(mclk),
    .rst_n(rst_n),
    .stamp_value(stamp_value),
    .wrap_pulse(wrap_pulse)
);

assign tx_abort = tx_fetch_late;

// Full level and loss of an event element.
wire fifo_full = (tx_event_size != 6'h00) && (tx_event_fill >= tx_event_size);
reg fifo_full_prev;
wire event_lost = tx_event_write && ((tx_event_size == 6'h00) || fifo_full);
wire full_rise = fifo_full && !fifo_full_prev;

// Collected set requests, bit 19 down to 14.
wire [5:0] set_vec;
assign set_vec[5] = rx_buffer_stored;
assign set_vec[4] = timeout_event;
assign set_vec[3] = rx_abort || tx_fetch_late;
assign set_vec[2] = wrap_pulse;
assign set_vec[1] = event_lost;
assign set_vec[0] = full_rise;

// ----------------------------------------------------------------------
// Registers
// ----------------------------------------------------------------------

reg [5:0] flags;
wire wr_flags = reg_wr && (reg_addr == `REG_EVENT_FLAGS);
wire wr_ctrl = reg_wr && (reg_addr == `REG_CONTROL);

// Sticky flags; writing one clears a bit.
always @(posedge mclk) begin
    if (!rst_n) begin
        flags <= 6'h00;
        fifo_full_prev <= 1'b0;
    end else begin
        fifo_full_prev <= fifo_full;
        if (wr_flags) begin
            flags <= (flags & ~reg_wdata[`FLAGS_HI:`FLAGS_LO]) | set_vec;
        end else begin
            flags <= flags | set_vec;
        end
    end
end

// Restricted operation select; hardware set wins over software clear.
always @(posedge mclk) begin
    if (!rst_n) begin
        restricted_operation_select <= 1'b0;
    end else if (tx_fetch_late) begin
        restricted_operation_select <= 1'b1;
    end else if (wr_ctrl) begin
        restricted_operation_select <= reg_wdata[`BIT_RESTRICTED_SELECT];
    end
end

assign flags_out = flags;

// Read data stands one cycle after the strobe; unmapped reads zero.
always @(posedge mclk) begin
    if (!rst_n) begin
        reg_rdata <= `EVENT_FLAGS_RESET;
    end else if (reg_rd) begin
        case (reg_addr)
            `REG_EVENT_FLAGS: reg_rdata <= {12'h000, flags, 14'h0000};
            `REG_CONTROL: reg_rdata <= {31'h00000000, restricted_operation_select};
            `REG_STATUS: reg_rdata <= {31'h00000000, fifo_full};
            default: reg_rdata <= 32'h00000000;
        endcase
    end else begin
        reg_rdata <= 32'h00000000;
    end
end

endmodule // can_interrupt_flags_hi_mid

/* can_interrupt_flags_hi_mid_tb.sv */
`timescale 1ns/10ps
`include "can_flags_consts.vh"
module can_interrupt_flags_hi_mid_tb;
    reg mclk = 1'b0;
    reg rst_n = 1'b0;
    reg [15:0] reg_addr = 16'h0000;
    reg [31:0] reg_wdata = 32'h00000000;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg [7:0] ev = 8'h00;
    reg [15:0] stamp_value = 16'h0000;
    reg [5:0] tx_event_size = 6'h00;
    reg [5:0] tx_event_fill = 6'h00;
    reg rd_d = 1'b0;
    reg [5:0] exp_f;
    reg [31:0] r;
    wire rx_busy, rx_store_done, rx_is_dedicated, rx_write_error;
    wire next_arbitration, tx_fetch_late, timeout_event, tx_event_write;
    wire [31:0] reg_rdata;
    wire [5:0] flags_out;
    wire rx_commit, rx_abort, tx_abort, restricted_operation_select;
    logic [31:0] q[$];
    logic [7:0] evs [6] = '{8'hE0, 8'h02, 8'h88, 8'h90, 8'h04, 8'h01};
    logic [5:0] bits [6] = '{6'h20, 6'h10, 6'h08, 6'h08, 6'h08, 6'h02};
    int error_cnt = 0;
    int checked = 0;
    int cyc = 0;
    assign {rx_busy, rx_store_done, rx_is_dedicated, rx_write_error, next_arbitration,
        tx_fetch_late, timeout_event, tx_event_write} = ev;
    can_interrupt_flags_hi_mid i_dut (.*);
    always #2 mclk = ~mclk;
    // Compares read data against the oldest note; cuts a hang.
    always @(posedge mclk) begin
        rd_d <= reg_rd;
        cyc <= cyc + 1;
        if (rd_d) cmp(q.pop_front());
        if (cyc == 3000) begin
            error_cnt++;
            finish_test();
        end
    end
    task cmp(input logic [31:0] e);
        checked++;
        if (reg_rdata !== e) begin
            error_cnt++;
            $display("ERROR reg_rdata expected %h seen %h", e, reg_rdata);
        end
    endtask
    task wr(input [15:0] a, input [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task rd(input [15:0] a, input [31:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        q.push_back(e);
        @(posedge mclk);
        reg_rd <= 1'b0;
    endtask
    task rf(input [5:0] f);
        rd(`REG_EVENT_FLAGS, {12'h000, f, 14'h0000});
    endtask
    task pulse(input [7:0] m);
        @(posedge mclk);
        ev <= m;
        @(posedge mclk);
        ev <= 8'h00;
    endtask
    task finish_test();
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Main sequence.
    initial begin
        void'($urandom(81376));
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        rf(6'h00);
        rd(16'h1000, 32'h00000000);
        for (int i = 0; i < 6; i++) begin
            pulse(evs[i]);
            rf(bits[i]);
            wr(`REG_EVENT_FLAGS, 32'hFFFFFFFF);
            rf(6'h00);
        end
        rd(`REG_CONTROL, 32'h00000001);
        wr(`REG_CONTROL, 32'h00000000);
        rd(`REG_CONTROL, 32'h00000000);
        $display("event test done");
        @(posedge mclk);
        stamp_value <= 16'hFFFF;
        @(posedge mclk);
        stamp_value <= 16'h0000;
        tx_event_size <= 6'h04;
        tx_event_fill <= 6'h04;
        rf(6'h05);
        pulse(8'h01);
        rf(6'h07);
        @(posedge mclk);
        ev <= 8'h02;
        reg_addr <= `REG_EVENT_FLAGS;
        reg_wdata <= 32'hFFFFFFFF;
        reg_wr <= 1'b1;
        @(posedge mclk);
        ev <= 8'h00;
        reg_wr <= 1'b0;
        rf(6'h10);
        exp_f = 6'h10;
        for (int i = 0; i < 8; i++) begin
            pulse(8'hE2);
            r = $urandom;
            wr(`REG_EVENT_FLAGS, r);
            exp_f = (exp_f | 6'h30) & ~r[19:14];
            rf(exp_f);
        end
        $display("clear test done");
        finish_test();
    end
endmodule // can_interrupt_flags_hi_mid_tb

/* flags_check_sva.sv */
`timescale 1ns/10ps
`include "can_flags_consts.vh"
// ----------------------------------------
// Checker
// ----------------------------------------
module flags_check (
    // Clock and reset
    input wire mclk,
    input wire rst_n,
    // Watched ports
    input wire reg_rd,
    input wire [31:0] reg_rdata,
    input wire rx_busy,
    input wire rx_store_done,
    input wire rx_is_dedicated,
    input wire rx_write_error,
    input wire next_arbitration,
    input wire rx_commit,
    input wire rx_abort,
    input wire tx_fetch_late,
    input wire tx_abort,
    input wire [`STAMP_W-1:0] stamp_value,
    input wire tx_event_write,
    input wire [5:0] tx_event_size,
    input wire restricted_operation_select,
    input wire [5:0] flags_out
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Counter top value followed by zero.
    sequence roll;
        stamp_value == `STAMP_MAX ##1 stamp_value == 16'h0000;
    endsequence
    // Each event ties an output to its cause.
    AST_DEDI: assert property (rx_commit && rx_is_dedicated |=> flags_out[5])
        else $error("store flag missing");
    AST_LATE: assert property (rx_busy && next_arbitration && !rx_store_done |-> rx_abort ##1 flags_out[3])
        else $error("late abort missing");
    AST_WFAIL: assert property (rx_busy && rx_write_error |-> rx_abort ##1 flags_out[3])
        else $error("write fail missing");
    AST_NOCOMMIT: assert property (rx_abort |-> !rx_commit)
        else $error("commit on abort");
    AST_TXAB: assert property (tx_fetch_late |-> tx_abort)
        else $error("tx abort missing");
    AST_RESTR: assert property (tx_fetch_late |=> restricted_operation_select && flags_out[3])
        else $error("restricted missing");
    AST_WRAP: assert property (roll |=> flags_out[2])
        else $error("wrap flag missing");
    AST_LOST: assert property (tx_event_write && tx_event_size == 6'h00 |=> flags_out[1])
        else $error("lost flag missing");
    AST_RDONE: assert property (!reg_rd |=> reg_rdata == 32'h00000000)
        else $error("read data lingers");
endmodule // flags_check

bind can_interrupt_flags_hi_mid flags_check i_check (.*);

/* rx_store_guard.v */
`timescale 1ns/10ps
`include "can_flags_consts.vh"

// Decides whether a receive storage completes or is aborted.
module rx_store_guard (
    // Clock and reset
    input wire mclk,
    input wire rst_n,
    // Receive handler progress
    input wire rx_busy,
    input wire rx_store_done,
    input wire rx_is_dedicated,
    input wire rx_write_error,
    input wire next_arbitration,
    // Outcomes
    output wire rx_commit,
    output wire rx_abort,
    output wire rx_buffer_stored
);

reg active;

// Late means the next arbitration field arrived while still busy.
// Late work detection.
wire late = (active || rx_busy) && next_arbitration && !rx_store_done;

// Abort on late work or a failed RAM write.
assign rx_abort = late || (rx_busy && rx_write_error);
// A write failure or lateness blocks the commit.
// No commit on abort.
assign rx_commit = rx_store_done && !rx_abort;
assign rx_buffer_stored = rx_commit && rx_is_dedicated;

// Tracks an unfinished receive job; a new one starts if next_arbitration comes with the store or abort.
always @(posedge mclk) begin
    if (!rst_n) begin
        active <= 1'b0;
    end else if (rx_store_done || rx_abort) begin
        active <= next_arbitration;
    end else if (rx_busy || next_arbitration) begin
        active <= 1'b1;
    end
end

endmodule // rx_store_guard

/* stamp_wrap_detect.v */
`timescale 1ns/10ps
`include "can_flags_consts.vh"

// Watches the timestamp counter and pulses when it rolls over to zero.
module stamp_wrap_detect (
    // Clock and reset
    input wire mclk,
    input wire rst_n,
    // Timestamp counter value
    input wire [`STAMP_W-1:0] stamp_value,
    // Rollover event
    output wire wrap_pulse
);

reg [`STAMP_W-1:0] stamp_prev;

// Previous counter value is held one cycle.
always @(posedge mclk) begin
    if (!rst_n) begin
        stamp_prev <= 16'h0000;
    end else begin
        stamp_prev <= stamp_value;
    end
end

// A step from maximum straight to zero is a wrap.
assign wrap_pulse = (stamp_prev == `STAMP_MAX) && (stamp_value == 16'h0000);

endmodule // stamp_wrap_detect
